// ### hw/gating_storage_access_control.v
// Gating storage access controller for one thread context
`include "gating_access_defs.vh"

module gating_storage_access_control #(
  parameter AW = 32,
  parameter DW = 32,
  parameter RW = 5
) (
  input wire core_clk, // Core clock, 20 MHz
  input wire rst, // Asynchronous reset, active high
  // APB slave
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output wire pready, // APB ready, always high
  output wire pslverr, // APB error on unmapped address
  // Translation result for the access in flight
  input wire page_gating, // Translation entry marks page gating
  input wire page_special, // Special page attribute present
  input wire [AW-1:0] phys_addr, // Translated address
  output wire route_to_gating, // This access belongs to this block
  // Request from the pipeline
  input wire req_valid, // Gating access request
  input wire req_load, // 1 load, 0 store
  input wire [DW-1:0] req_wdata, // Store data
  input wire [RW-1:0] req_dest, // Load destination register
  input wire [AW-1:0] req_pc, // Pc of the access
  input wire req_bd, // Access sits in a branch delay slot
  output wire req_ready, // Request accepted
  output wire commit_hold, // Stall later instructions
  output reg dest_busy, // Destination interlock active
  output reg [RW-1:0] dest_reg, // Interlocked register
  output reg wb_valid, // Load data write-back pulse
  output reg [DW-1:0] wb_data, // Load data
  output reg store_done, // Store confirmed pulse
  // Exception machinery
  input wire exc_taken, // Any exception taken on this context
  output reg thread_exc, // Thread exception pulse
  output reg [`EXC_W-1:0] thread_exception_code, // Code with pulse
  output reg [AW-1:0] exception_return_pc, // Restart pc
  output reg branch_delay_flag, // Restart sits in delay slot
  output reg restart_at_access, // Access must be re-issued
  output wire thread_halted, // Halt bit from control
  output wire irq, // Interrupt, level high
  // Gating storage subsystem
  output reg gs_req_valid, // Access request
  output reg gs_req_load, // 1 load, 0 store
  output reg [AW-1:0] gs_addr, // Access address
  output reg [DW-1:0] gs_wdata, // Store data
  output wire gs_uncached, // Always high
  input wire gs_req_ready, // Subsystem takes request
  input wire gs_resp_valid, // Answer strobe
  input wire [1:0] gs_resp_kind, // Data, confirm or exception
  input wire [DW-1:0] gs_rdata, // Load data
  input wire gs_blocked, // Access found blocked
  output reg gs_abort, // Abort pulse
  input wire gs_abort_ack, // Abort outcome strobe
  input wire gs_abort_completed // 1 completed, 0 abandoned
);

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  reg [`CTRL_W-1:0] ctrl;
  reg [AW-1:0] gs_base;
  reg [AW-1:0] gs_limit;
  reg [`ST_W-1:0] state;
  reg [`ST_W-1:0] next_state;
  reg sched_abort;
  reg saved_load;
  reg [AW-1:0] saved_pc;
  reg saved_bd;
  reg halt_q;
  reg [`EV_W-1:0] events;
  wire [`EV_W-1:0] status;
  wire [`EV_W-1:0] mask;
  wire apb_wr;
  wire apb_rd;
  wire mapped;
  wire in_range;
  wire abort_cause;

  function is_reg;
    input [7:0] a;
    begin
      is_reg = (a == `REG_CTRL) || (a == `REG_STATUS) ||
        (a == `REG_MASK) || (a == `REG_STATE) ||
        (a == `REG_GS_BASE) || (a == `REG_GS_LIMIT) ||
        (a == `REG_RETPC);
    end
  endfunction

  // ----------------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------------
  assign mapped = is_reg(paddr);
  assign apb_wr = psel && penable && pwrite && mapped;
  assign apb_rd = psel && penable && !pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Software written control and window registers
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= `CTRL_RESET;
      gs_base <= `GS_BASE_RESET;
      gs_limit <= `GS_LIMIT_RESET;
    end
    else if (apb_wr)
    begin
      if (paddr == `REG_CTRL)
        ctrl <= pwdata[`CTRL_W-1:0];
      if (paddr == `REG_GS_BASE)
        gs_base <= pwdata[AW-1:0];
      if (paddr == `REG_GS_LIMIT)
        gs_limit <= pwdata[AW-1:0];
    end
  end

  // Read mux, unmapped reads return zero
  always @*
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: prdata[`CTRL_W-1:0] = ctrl;
      `REG_STATUS: prdata[`EV_W-1:0] = status;
      `REG_MASK: prdata[`EV_W-1:0] = mask;
      `REG_STATE:
      begin
        prdata[`ST_W-1:0] = state;
        prdata[8+`EXC_W-1:8] = thread_exception_code;
        prdata[16] = dest_busy;
        prdata[17] = restart_at_access;
      end
      `REG_GS_BASE: prdata[AW-1:0] = gs_base;
      `REG_GS_LIMIT: prdata[AW-1:0] = gs_limit;
      `REG_RETPC: prdata[AW-1:0] = exception_return_pc;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Status flags, mask and interrupt
  event_status #(
    .N(`EV_W)
  ) u_events (
    .core_clk(core_clk),
    .rst(rst),
    .event_pulse(events),
    .status_read(apb_rd && (paddr == `REG_STATUS)),
    .mask_write(apb_wr && (paddr == `REG_MASK)),
    .mask_wdata(pwdata[`EV_W-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Classification of the access
  // ----------------------------------------------------------------------
  // Window and attribute checks are off after reset, so any mapped
  // page marked gating is handled here
  assign in_range = !ctrl[`CTRL_RANGE_EN] ||
    ((phys_addr >= gs_base) && (phys_addr <= gs_limit));
  assign route_to_gating = page_gating && in_range &&
    (!ctrl[`CTRL_ATTR_REQ] || page_special);

  // One access at a time; a halted context issues nothing new
  assign req_ready = (state == `ST_IDLE) && !ctrl[`CTRL_HALT] &&
    route_to_gating;
  assign gs_uncached = 1'b1;
  assign thread_halted = ctrl[`CTRL_HALT];
  // Nothing after the access may change visible state until it ends
  assign commit_hold = (state != `ST_IDLE);

  // Abort on any exception, or on the rising edge of the halt bit
  assign abort_cause = exc_taken ||
    (ctrl[`CTRL_HALT] && !halt_q);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      `ST_IDLE:
        if (req_valid && req_ready)
          next_state = `ST_ISSUE;
      `ST_ISSUE:
        if (gs_req_ready)
          next_state = abort_cause ? `ST_ABORT : `ST_WAIT;
        else if (abort_cause)
          next_state = `ST_IDLE;
      `ST_WAIT:
        if (gs_resp_valid)
          next_state = `ST_IDLE;
        else if (abort_cause)
          next_state = `ST_ABORT;
        else if (gs_blocked && ctrl[`CTRL_GSI] && ctrl[`CTRL_DIRTY])
          next_state = `ST_ABORT;
      `ST_ABORT:
        next_state = `ST_ABWAIT;
      `ST_ABWAIT:
        if (gs_abort_ack)
          next_state = `ST_IDLE;
      default:
        next_state = `ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencing and outputs
  // ----------------------------------------------------------------------
  // Request fields are latched once, so each store goes out on its own
  // and is never combined with a neighbour
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= `ST_IDLE;
      halt_q <= 1'b0;
      sched_abort <= 1'b0;
      saved_load <= 1'b0;
      saved_pc <= {AW{1'b0}};
      saved_bd <= 1'b0;
      gs_req_valid <= 1'b0;
      gs_req_load <= 1'b0;
      gs_addr <= {AW{1'b0}};
      gs_wdata <= {DW{1'b0}};
      gs_abort <= 1'b0;
      dest_busy <= 1'b0;
      dest_reg <= {RW{1'b0}};
      wb_valid <= 1'b0;
      wb_data <= {DW{1'b0}};
      store_done <= 1'b0;
      thread_exc <= 1'b0;
      thread_exception_code <= `EXC_NONE;
      exception_return_pc <= {AW{1'b0}};
      branch_delay_flag <= 1'b0;
      restart_at_access <= 1'b0;
      events <= {`EV_W{1'b0}};
    end
    else
    begin
      state <= next_state;
      halt_q <= ctrl[`CTRL_HALT];
      wb_valid <= 1'b0;
      store_done <= 1'b0;
      thread_exc <= 1'b0;
      gs_abort <= 1'b0;
      events <= {`EV_W{1'b0}};
      case (state)
        `ST_IDLE:
          if (req_valid && req_ready)
          begin
            gs_req_valid <= 1'b1;
            gs_req_load <= req_load;
            gs_addr <= phys_addr;
            gs_wdata <= req_wdata;
            saved_load <= req_load;
            saved_pc <= req_pc;
            saved_bd <= req_bd;
            dest_busy <= req_load;
            dest_reg <= req_dest;
            restart_at_access <= 1'b0;
          end
        `ST_ISSUE:
          if (gs_req_ready)
          begin
            // Taken in the abort cycle: storage owns it, so tell it
            gs_req_valid <= 1'b0;
            gs_abort <= abort_cause;
          end
          else if (abort_cause)
          begin
            // Never reached storage: abandoned locally, nothing to undo
            gs_req_valid <= 1'b0;
            dest_busy <= 1'b0;
            exception_return_pc <= saved_pc;
            branch_delay_flag <= saved_bd;
            restart_at_access <= 1'b1;
            events[`EV_ABANDON] <= 1'b1;
          end
        `ST_WAIT:
          if (gs_resp_valid)
          begin
            events[`EV_DONE] <= 1'b1;
            dest_busy <= 1'b0;
            if (gs_resp_kind == `RESP_EXC)
            begin
              thread_exc <= 1'b1;
              thread_exception_code <= `EXC_GATING;
              exception_return_pc <= saved_pc;
              branch_delay_flag <= saved_bd;
              restart_at_access <= 1'b1;
              events[`EV_GS_EXC] <= 1'b1;
            end
            else if (saved_load)
            begin
              // Same result as an ordinary load, just later
              wb_valid <= 1'b1;
              wb_data <= gs_rdata;
            end
            else
              store_done <= 1'b1;
          end
          else if (abort_cause ||
            (gs_blocked && ctrl[`CTRL_GSI] && ctrl[`CTRL_DIRTY]))
          begin
            // External causes win; the scheduler trap is only taken
            // when no other exception already owns the context
            gs_abort <= 1'b1;
            sched_abort <= !abort_cause;
          end
        `ST_ABWAIT:
          if (gs_abort_ack)
          begin
            if (gs_abort_completed)
            begin
              // Finished anyway: retire it, resume after it
              events[`EV_ABORT_DONE] <= 1'b1;
              dest_busy <= 1'b0;
              wb_valid <= saved_load;
              wb_data <= gs_rdata;
              store_done <= !saved_load;
              restart_at_access <= 1'b0;
            end
            else
            begin
              // Abandoned: register keeps its old value, access replays
              events[`EV_ABANDON] <= 1'b1;
              dest_busy <= 1'b0;
              exception_return_pc <= saved_pc;
              branch_delay_flag <= saved_bd;
              restart_at_access <= 1'b1;
              if (sched_abort)
              begin
                thread_exc <= 1'b1;
                thread_exception_code <= `EXC_SCHED;
                events[`EV_SCHED_EXC] <= 1'b1;
              end
            end
            sched_abort <= 1'b0;
          end
        default:
          gs_req_valid <= 1'b0;
      endcase
    end
  end

endmodule // gating_storage_access_control

// ### hw/gating_access_defs.vh
// Constants shared by the gating storage access controller
`ifndef GATING_ACCESS_DEFS_VH
`define GATING_ACCESS_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_STATE 8'h0C
`define REG_GS_BASE 8'h10
`define REG_GS_LIMIT 8'h14
`define REG_RETPC 8'h18

// ----------------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------------
`define CTRL_GSI 0
`define CTRL_DIRTY 1
`define CTRL_HALT 2
`define CTRL_RANGE_EN 3
`define CTRL_ATTR_REQ 4
`define CTRL_W 5
`define CTRL_RESET 5'h00
`define GS_BASE_RESET 32'h0000_0000
`define GS_LIMIT_RESET 32'hFFFF_FFFF

// ----------------------------------------------------------------------
// Event bits of the status register
// ----------------------------------------------------------------------
`define EV_DONE 0
`define EV_GS_EXC 1
`define EV_SCHED_EXC 2
`define EV_ABANDON 3
`define EV_ABORT_DONE 4
`define EV_W 5

// ----------------------------------------------------------------------
// Thread exception codes and storage answer kinds
// ----------------------------------------------------------------------
`define EXC_W 4
`define EXC_NONE 4'h0
`define EXC_GATING 4'h3
`define EXC_SCHED 4'h5
`define RESP_DATA 2'h0
`define RESP_CONFIRM 2'h1
`define RESP_EXC 2'h2

// ----------------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------------
`define ST_W 3
`define ST_IDLE 3'h0
`define ST_ISSUE 3'h1
`define ST_WAIT 3'h2
`define ST_ABORT 3'h3
`define ST_ABWAIT 3'h4

`endif

// ### hw/event_status.v
// Sticky event flags with read-to-clear, mask and level interrupt
module event_status #(
  parameter N = 5
) (
  input wire core_clk, // Core clock
  input wire rst, // Asynchronous reset, active high
  input wire [N-1:0] event_pulse, // One-cycle event strobes
  input wire status_read, // Read of status register clears flags
  input wire mask_write, // Write strobe for the mask register
  input wire [N-1:0] mask_wdata, // New mask value
  output reg [N-1:0] status, // Sticky flags
  output reg [N-1:0] mask, // Interrupt enables
  output wire irq // Level interrupt
);

  // ----------------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------------
  // Set beats the read-clear so no event is lost in the clearing cycle
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status <= {N{1'b0}};
    else if (status_read)
      status <= event_pulse;
    else
      status <= status | event_pulse;
  end

  // Mask register
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mask <= {N{1'b0}};
    else if (mask_write)
      mask <= mask_wdata;
  end

  // Interrupt stays high while any enabled flag is set
  assign irq = |(status & mask);

endmodule // event_status

// ### verif/gating_access_assertions.sv
// Port-level checker for the gating storage access controller
`include "gating_access_defs.vh"
module gating_access_checker #(
  parameter AW = 32,
  parameter DW = 32
) (
  input wire core_clk, // Clock
  input wire rst, // Reset
  input wire req_valid, // Request
  input wire req_ready, // Taken
  input wire [AW-1:0] phys_addr, // Address
  input wire gs_req_valid, // Issue
  input wire [AW-1:0] gs_addr, // Issued address
  input wire commit_hold, // Stall
  input wire gs_uncached, // No cache
  input wire gs_resp_valid, // Answer
  input wire [1:0] gs_resp_kind, // Answer kind
  input wire [DW-1:0] gs_rdata, // Answer data
  input wire dest_busy, // Interlock
  input wire wb_valid, // Write-back
  input wire [DW-1:0] wb_data, // Load data
  input wire store_done, // Store done
  input wire thread_exc, // Exception
  input wire [`EXC_W-1:0] thread_exception_code, // Code
  input wire exc_taken, // Outside exception
  input wire gs_abort, // Abort
  input wire gs_abort_ack, // Abort outcome
  input wire gs_abort_completed, // Completed
  input wire restart_at_access, // Re-issue
  input wire thread_halted, // Halted
  input wire route_to_gating // Gating page
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------
  // Access sequencing
  // ---------------------------------------------
  sequence acc_taken;
    req_valid && req_ready;
  endsequence
  sequence abandon_seen;
    gs_abort_ack && !gs_abort_completed;
  endsequence
  // One issue per taken request, same word
  issue_holds_a:
    assert property (acc_taken |=> gs_req_valid && commit_hold &&
      gs_addr == $past(phys_addr)) else $error("Issue wrong");
  never_cached_a:
    assert property (gs_uncached) else $error("Cached access");
  hold_while_out_a:
    assert property (gs_req_valid |-> commit_hold && !req_ready)
      else $error("Pipeline not held");
  gating_code_a:
    assert property (gs_resp_valid && gs_resp_kind == `RESP_EXC &&
      commit_hold && !gs_req_valid |=> thread_exc &&
      thread_exception_code == `EXC_GATING && restart_at_access)
      else $error("Storage exception lost");
  load_result_a:
    assert property (gs_resp_valid && gs_resp_kind == `RESP_DATA &&
      dest_busy |=> wb_valid && wb_data == $past(gs_rdata) && !dest_busy)
      else $error("Load result wrong");
  store_once_a:
    assert property (gs_resp_valid && gs_resp_kind == `RESP_CONFIRM &&
      commit_hold && !dest_busy && !gs_req_valid |=>
      store_done ##1 !store_done) else $error("Store confirm wrong");
  abort_on_exc_a:
    assert property (exc_taken && commit_hold && !gs_req_valid &&
      !gs_resp_valid && !gs_abort && !gs_abort_ack |=> gs_abort)
      else $error("No abort on exception");
  abort_pulse_a:
    assert property (gs_abort |=> !gs_abort) else $error("Abort too long");
  abandon_release_a:
    assert property (abandon_seen |-> ##[1:2]
      (restart_at_access && !dest_busy)) else $error("Abandon unclean");
  refuse_idle_a:
    assert property (thread_halted || !route_to_gating |-> !req_ready)
      else $error("Request taken while barred");
  code_legal_a:
    assert property (thread_exc |-> thread_exception_code == `EXC_GATING
      || thread_exception_code == `EXC_SCHED) else $error("Bad code");
endmodule // gating_access_checker

// ### verif/gating_storage_model.sv
// Behavioural model of the gating storage subsystem
module gating_storage_model (
  input wire core_clk, // Clock
  input wire rst, // Reset
  input wire gs_req_valid, // Request
  input wire gs_abort, // Abort
  input wire [3:0] dly, // Answer delay
  input wire [1:0] kind, // Answer kind
  input wire hang, // Never answer
  input wire blk, // Report blocked
  input wire comp, // Abort completes
  input wire [31:0] data, // Load data
  output logic gs_req_ready, // Taken
  output logic gs_resp_valid, // Answer
  output logic [1:0] gs_resp_kind, // Kind
  output logic [31:0] gs_rdata, // Data
  output logic gs_blocked, // Blocked
  output logic gs_abort_ack, // Outcome
  output logic gs_abort_completed // Completed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  logic [4:0] cnt;
  // ---------------------------------------------
  // Take, answer, abort
  // ---------------------------------------------
  // One outcome per access, abort answered once
  always @(posedge core_clk or posedge rst)
    if (rst)
    begin
      {busy, cnt, gs_req_ready, gs_resp_valid, gs_blocked} <= '0;
      {gs_abort_ack, gs_abort_completed, gs_resp_kind} <= '0;
      gs_rdata <= 32'h5a5a_5a5a;
    end
    else
    begin
      {gs_resp_valid, gs_blocked, gs_abort_ack} <= '0;
      gs_rdata <= ~gs_rdata; // Idle data never looks valid
      cnt <= cnt + 5'h01;
      if (gs_abort)
      begin
        busy <= 1'b0;
        gs_abort_ack <= 1'b1;
        // Already answered when the abort crossed it: report completed
        gs_abort_completed <= comp || !busy;
        gs_rdata <= data;
      end
      else if (!busy)
      begin
        gs_req_ready <= gs_req_valid && !gs_req_ready && cnt >= dly;
        busy <= gs_req_valid && gs_req_ready;
        if (!gs_req_valid || gs_req_ready)
          cnt <= 5'h00;
      end
      else if (blk && cnt == 5'h01)
        gs_blocked <= 1'b1;
      else if (!hang && cnt == {1'b0, dly} + 5'h02)
      begin
        busy <= 1'b0;
        gs_resp_valid <= 1'b1;
        gs_resp_kind <= kind;
        gs_rdata <= data;
      end
    end
endmodule // gating_storage_model

// ### verif/gating_storage_access_control_bench.sv
// Self-checking bench for the gating storage access controller
`include "gating_access_defs.vh"
module gating_storage_access_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, page_gating = 1'b1, page_special = 1'b0;
  logic req_valid = 1'b0, req_load = 1'b0, req_bd = 1'b0;
  logic exc_taken = 1'b0, hang = 1'b0, blk = 1'b0, comp = 1'b0, serr;
  logic [7:0] paddr = 8'h00;
  logic [4:0] req_dest = 5'h00, dest_reg;
  logic [3:0] thread_exception_code, dly = 4'h0;
  logic [1:0] gs_resp_kind, kind = 2'h0;
  logic [31:0] pwdata = '0, phys_addr = '0, req_wdata = '0, req_pc = '0;
  logic [31:0] prdata, wb_data, exception_return_pc, gs_addr, gs_wdata;
  logic [31:0] gs_rdata, data = '0, seed = 32'h0000_e6c5, q, got_data;
  logic pready, pslverr, route_to_gating, req_ready, commit_hold, irq;
  logic dest_busy, wb_valid, store_done, thread_exc, branch_delay_flag;
  logic restart_at_access, thread_halted, gs_req_valid, gs_req_load;
  logic gs_uncached, gs_abort, gs_req_ready, gs_resp_valid, gs_blocked;
  logic gs_abort_ack, gs_abort_completed;
  int err_total = 0, n_tests = 0, n_wb = 0, n_sd = 0, n_exc = 0;

  gating_storage_access_control DUT (.*);
  gating_storage_model partner (.*);

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  // Tally result pulses; judged when the access ends
  always @(posedge core_clk)
  begin
    if (wb_valid)
      got_data <= wb_data;
    n_wb <= n_wb + int'(wb_valid);
    n_sd <= n_sd + int'(store_done);
    n_exc <= n_exc + int'(thread_exc);
  end

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Outcome of a case: {restart, exception, store, load}
  function automatic logic [3:0] outcome(input int c, input logic ld);
    logic ok;
    ok = c == 0 || c == 1 || c == 4 || c == 6;
    return {c == 2 || c == 3 || c == 5 || c == 7, c == 2 || c == 5,
      ok && !ld, ok && ld};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A used-up wait counts as a mismatch and ends the run
  task automatic tmo(input int i);
    if (i >= 40)
    begin
      err_total++;
      stop_test();
    end
  endtask

  // APB transfer, then one idle cycle so psel never toggles twice
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    tmo(i);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // One gating access of case c with random payload
  task automatic access(input int c);
    int i, w0, s0, e0;
    logic [31:0] s;
    logic [3:0] o;
    logic ld;
    s = rnd();
    ld = s[0];
    o = outcome(c, ld);
    apb(1'b1, `REG_CTRL, c == 5 ? 32'h0000_0003 : {31'h0, c == 6});
    {w0, s0, e0} = {n_wb, n_sd, n_exc};
    dly <= c == 1 ? 4'h0 : {2'h0, s[2:1]};
    kind <= c == 2 ? `RESP_EXC : ld ? `RESP_DATA : `RESP_CONFIRM;
    {hang, blk, comp} <= {c > 2 && c != 6, c == 5 || c == 6, c == 4};
    {data, phys_addr, req_wdata, req_pc} <= {rnd(), rnd(), rnd(), rnd()};
    {req_bd, req_dest, req_load, req_valid} <= {s[3], s[8:4], ld, 1'b1};
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      if (req_ready === 1'b1)
        break;
    end
    tmo(i);
    req_valid <= 1'b0;
    repeat (8) @(posedge core_clk);
    if (c == 3 || c == 4)
    begin
      exc_taken <= 1'b1;
      @(posedge core_clk);
      exc_taken <= 1'b0;
    end
    if (c == 7)
      apb(1'b1, `REG_CTRL, 32'h0000_0004);
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      if (commit_hold === 1'b0)
        break;
    end
    tmo(i);
    @(posedge core_clk);
    chk(n_wb - w0, o[0]);
    chk(n_sd - s0, o[1]);
    chk(n_exc - e0, o[2]);
    chk(restart_at_access, o[3]);
    chk(dest_busy, 1'b0);
    chk({gs_req_load, dest_reg}, {ld, req_dest});
    chk(gs_wdata, req_wdata);
    if (o[0])
      chk(got_data, data);
    if (o[2])
      chk(thread_exception_code, c == 5 ? `EXC_SCHED : `EXC_GATING);
    if (o[3])
      chk({exception_return_pc, branch_delay_flag}, {req_pc, req_bd});
    if (c == 7)
      chk({thread_halted, req_ready}, 2'b10);
    $display("Case %0d load %0d done", c, ld);
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, `REG_CTRL, '0);
    chk(q, '0);
    apb(1'b0, `REG_GS_LIMIT, '0);
    chk(q, 32'hffff_ffff);
    apb(1'b1, 8'h40, rnd());
    chk({serr, q}, {1'b1, 32'h0});
    page_gating <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(req_ready, 1'b0);
    page_gating <= 1'b1;
    // Address window and page attribute limits
    apb(1'b1, `REG_GS_BASE, 32'h0000_1000);
    apb(1'b1, `REG_GS_LIMIT, 32'h0000_1fff);
    apb(1'b1, `REG_CTRL, 32'h0000_0018);
    {page_special, phys_addr} <= {1'b1, 32'h0000_1800};
    @(posedge core_clk);
    chk(route_to_gating, 1'b1);
    phys_addr <= 32'h0000_2000;
    @(posedge core_clk);
    chk(route_to_gating, 1'b0);
    {page_special, phys_addr} <= {1'b0, 32'h0000_1800};
    @(posedge core_clk);
    chk(route_to_gating, 1'b0);
    $display("Window test done");
    for (int k = 0; k < 32; k++)
      access(k % 8);
    // Last case was a halt abandon, last code the scheduler one
    apb(1'b0, `REG_RETPC, '0);
    chk(q, req_pc);
    apb(1'b0, `REG_STATE, '0);
    chk(q, {14'h0, 2'b10, 4'h0, `EXC_SCHED, 8'h00});
    apb(1'b1, `REG_MASK, 32'h0000_0001);
    apb(1'b0, `REG_STATUS, '0);
    access(0);
    chk(irq, 1'b1);
    apb(1'b0, `REG_STATUS, '0);
    chk(q[`EV_DONE], 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, `REG_MASK, '0);
    access(1);
    chk(irq, 1'b0);
    $display("Interrupt test done");
    stop_test();
  end
endmodule // gating_storage_access_control_bench

bind gating_storage_access_control gating_access_checker
  #(.AW(AW), .DW(DW)) chk_u (.*);
